// ---- rtl/csu_pkg.sv ----
// What this block does
// - each channel matches on the top ten address bits, start inclusive, end exclusive
// - bits beneath the range field count as zero: ten for memory, six for I/O
// - ranges run in 1K byte steps for memory and 64 byte steps for I/O
// - without ignore-end, the last selected address is one below the full end address
// - ignore-end extends the range to FFFFFH in memory or 0FFFFH in I/O
// - the four-bit wait field inserts 0 to 15 automatic wait states
// - with ready control set, programmed waits come first, then wait for external ready
// - with ready control clear, exactly the programmed waits; external ready ignored
// - overlapping enabled channels all assert together on a shared address
// - overlap with no ready control uses the largest wait count among matches
// - overlap with any ready control uses the smallest wait count, then external ready
// - a channel asserts only when enabled; a disabled select stays high
// - space bit set means memory accesses only, clear means I/O accesses only
// - selects assert only for internal cycles, never for an external bus master
// - while the bus is held away, all selects are driven inactive high
// - matches are decided before the address and selects appear with it in T1
// - after reset only the boot channel is enabled, memory FFC00H to FFFFFH
// - the boot channel resets to fifteen wait states with ready control on
// - after reset the port 1 pins idle high; port1_csu_sel picks general selects or port data
// - selects stay high during any access to the peripheral control block
package csu_pkg;
  localparam int NUM_CH = 10;
  localparam int NUM_GEN = 8;
  localparam int FIELD_W = 10;
  localparam int WAIT_W = 4;
  localparam int DATA_W = 16;
  localparam int PCB_ADDR_W = 8;
  localparam int ADDR_W = 20;
  localparam int IO_ADDR_W = 16;
  localparam int CH_IDX_W = 4;
  // register map, byte offsets in the peripheral control block
  localparam logic [PCB_ADDR_W-1:0] REG_BASE = 8'h80;
  localparam logic [PCB_ADDR_W-1:0] REG_SPAN = 8'h28;
  localparam int REG_STRIDE_SHIFT = 2;
  localparam int END_SEL_BIT = 1;
  // field layout
  localparam int FIELD_LSB = 6;
  localparam int WAIT_LSB = 0;
  localparam int EN_BIT = 3;
  localparam int IGN_END_BIT = 2;
  localparam int MEM_BIT = 1;
  localparam int RDY_BIT = 0;
  // channel numbering: 0..7 general, 8 lower, 9 upper boot
  localparam int LOWER_CH = 8;
  localparam int BOOT_CH = 9;
  // reset values
  localparam logic [DATA_W-1:0] BOOT_START_RST = 16'hffcf;
  localparam logic [DATA_W-1:0] BOOT_END_RST = 16'hffcf;
  localparam logic [DATA_W-1:0] CH_RST = 16'h0000;
  localparam logic [NUM_GEN-1:0] PORT_IDLE = 8'hff;

  typedef enum logic [1:0]
  {
    TMR_IDLE = 2'b00,
    TMR_COUNT = 2'b01,
    TMR_EXT = 2'b10
  } tmr_state_t;

  // upper ten bits of the current address in its own space
  function automatic logic [FIELD_W-1:0] addr_field(input logic [ADDR_W-1:0] a,
                                                    input logic mem);
    addr_field = mem ? a[ADDR_W-1 -: FIELD_W] : a[IO_ADDR_W-1 -: FIELD_W];
  endfunction

  function automatic logic [FIELD_W-1:0] range_field(input logic [DATA_W-1:0] r);
    range_field = r[FIELD_LSB +: FIELD_W];
  endfunction
endpackage

// ---- rtl/wait_ready_timer.sv ----
`timescale 1ns/10ps
module wait_ready_timer
  import csu_pkg::*;
#(
  parameter int CNT_W = WAIT_W
)
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic load,
  input wire logic [CNT_W-1:0] wait_count,
  input wire logic use_ext,
  input wire logic ext_ready,
  input wire logic abort,
  output logic ready
);
  generate
    if (CNT_W < 1)
    begin : g_chk
      $error("wait counter width must be at least one");
    end
  endgenerate

  // =====================================================================
  // wait state counter
  tmr_state_t state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic ext_reg;
  logic ready_reg, ready_next;
  wire cnt_done = (cnt_reg == '0);

  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    ready_next = 1'b0;
    unique case (state_reg)
      TMR_IDLE:
      begin
        if (load)
        begin
          state_next = TMR_COUNT;
          cnt_next = wait_count;
        end
      end
      TMR_COUNT:
      begin
        if (!cnt_done)
          cnt_next = cnt_reg - 1'b1;
        else if (ext_reg && !ext_ready)
          state_next = TMR_EXT;
        else
        begin
          ready_next = 1'b1;
          state_next = TMR_IDLE;
        end
      end
      TMR_EXT:
      begin
        if (ext_ready)
        begin
          ready_next = 1'b1;
          state_next = TMR_IDLE;
        end
      end
      default:
        state_next = TMR_IDLE;
    endcase
    if (abort)
    begin
      state_next = TMR_IDLE;
      ready_next = 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      state_reg <= TMR_IDLE;
      cnt_reg <= '0;
      ext_reg <= 1'b0;
      ready_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      ready_reg <= ready_next;
      if (load && state_reg == TMR_IDLE)
        ext_reg <= use_ext;
    end
  end

  assign ready = ready_reg;

  // =====================================================================
  // checks
  logic [CNT_W:0] waited_reg;
  logic [CNT_W-1:0] held_reg;
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      waited_reg <= '0;
      held_reg <= '0;
    end
    else if (load && state_reg == TMR_IDLE)
    begin
      waited_reg <= '0;
      held_reg <= wait_count;
    end
    else if (state_reg == TMR_COUNT && !cnt_done)
      waited_reg <= waited_reg + 1'b1;
  end

  fixed_wait_len_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_reg == TMR_COUNT && cnt_done && !ext_reg && !abort)
      |-> waited_reg == {1'b0, held_reg})
    else $error("automatic wait count differs from programmed value");

  ext_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_reg == TMR_EXT && !ext_ready) |=> !ready_reg)
    else $error("cycle ended without external ready");

  no_ext_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_reg == TMR_COUNT && cnt_done && !ext_reg && !abort) |=> ready_reg)
    else $error("fixed wait cycle did not end after its wait states");

  ext_wait_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_reg == TMR_COUNT && cnt_done && ext_reg && !ext_ready) |=> !ready_reg)
    else $error("cycle ended before external ready after the wait states");

  ext_now_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_reg == TMR_COUNT && cnt_done && ext_reg && ext_ready && !abort) |=> ready_reg)
    else $error("external ready already high but cycle was stretched");

  ext_done_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_reg == TMR_EXT && ext_ready && !abort) |=> ready_reg)
    else $error("external ready seen but cycle not ended");
endmodule

// ---- rtl/chip_select_wait_state_unit.sv ----
`timescale 1ns/10ps
module chip_select_wait_state_unit
  import csu_pkg::*;
#(
  parameter int CHANNELS = NUM_CH,
  parameter int GEN_CHANNELS = NUM_GEN
)
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic pcb_wr,
  input wire logic pcb_rd,
  input wire logic [PCB_ADDR_W-1:0] pcb_addr,
  input wire logic [DATA_W-1:0] pcb_wdata,
  output logic [DATA_W-1:0] pcb_rdata,
  input wire logic cycle_start,
  input wire logic cycle_end,
  input wire logic [ADDR_W-1:0] cycle_addr,
  input wire logic cycle_mem,
  input wire logic cycle_internal,
  input wire logic pcb_access,
  input wire logic hold_active,
  input wire logic ext_ready,
  input wire logic [GEN_CHANNELS-1:0] port1_csu_sel,
  input wire logic [GEN_CHANNELS-1:0] port1_data,
  output logic [GEN_CHANNELS-1:0] port1_pins,
  output logic lower_region_select_n,
  output logic upper_boot_select_n,
  output logic csu_claim,
  output logic csu_ready
);
  generate
    if (CHANNELS != NUM_CH || GEN_CHANNELS != NUM_GEN)
    begin : g_chk
      $error("channel counts are fixed by the register map");
    end
  endgenerate

  // =====================================================================
  // register file
  logic [DATA_W-1:0] start_reg [CHANNELS];
  logic [DATA_W-1:0] end_reg [CHANNELS];
  logic [DATA_W-1:0] rdata_reg, rdata_next;

  wire [PCB_ADDR_W-1:0] rel_addr = pcb_addr - REG_BASE;
  wire reg_hit = (pcb_addr >= REG_BASE) && (rel_addr < REG_SPAN) && !pcb_addr[0];
  wire [CH_IDX_W-1:0] reg_ch = rel_addr[REG_STRIDE_SHIFT +: CH_IDX_W];
  wire reg_is_end = rel_addr[END_SEL_BIT];

  assign rdata_next = !(pcb_rd && reg_hit) ? '0 :
                      reg_is_end ? end_reg[reg_ch] : start_reg[reg_ch];

  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi++)
    begin : g_regs
      localparam logic [DATA_W-1:0] START_INIT = (gi == BOOT_CH) ? BOOT_START_RST : CH_RST;
      localparam logic [DATA_W-1:0] END_INIT = (gi == BOOT_CH) ? BOOT_END_RST : CH_RST;
      wire wr_this = pcb_wr && reg_hit && (reg_ch == CH_IDX_W'(gi));
      always_ff @(posedge clk_sys)
      begin
        if (!reset_n)
        begin
          start_reg[gi] <= START_INIT;
          end_reg[gi] <= END_INIT;
        end
        else if (wr_this && !reg_is_end)
          start_reg[gi] <= pcb_wdata;
        else if (wr_this && reg_is_end)
          end_reg[gi] <= pcb_wdata;
      end
    end
  endgenerate

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      rdata_reg <= '0;
    else
      rdata_reg <= rdata_next;
  end

  assign pcb_rdata = rdata_reg;

  // =====================================================================
  // address decode per channel
  logic [CHANNELS-1:0] match;
  logic [CHANNELS-1:0] ch_rdy;
  logic [CHANNELS*WAIT_W-1:0] ch_wait;
  logic [CHANNELS-1:0] ch_en;

  generate
    for (gi = 0; gi < CHANNELS; gi++)
    begin : g_dec
      wire en = end_reg[gi][EN_BIT];
      wire ign_end = end_reg[gi][IGN_END_BIT];
      wire mem = end_reg[gi][MEM_BIT];
      wire [FIELD_W-1:0] lo = range_field(start_reg[gi]);
      wire [FIELD_W-1:0] hi = range_field(end_reg[gi]);
      // low bits below the field read as zero, so compare fields only
      wire [FIELD_W-1:0] a = addr_field(cycle_addr, cycle_mem);
      wire io_in_space = cycle_mem || (cycle_addr[ADDR_W-1:IO_ADDR_W] == '0);
      wire above_start = (a >= lo);
      wire below_end = ign_end || (a < hi);
      wire space_ok = (mem == cycle_mem) && io_in_space;
      assign match[gi] = en && space_ok && above_start && below_end;
      assign ch_rdy[gi] = end_reg[gi][RDY_BIT];
      assign ch_wait[gi*WAIT_W +: WAIT_W] = start_reg[gi][WAIT_LSB +: WAIT_W];
      assign ch_en[gi] = en;
    end
  endgenerate

  // =====================================================================
  // wait merging over overlapping channels
  function automatic logic [WAIT_W-1:0] merge_waits(input logic [CHANNELS-1:0] m,
                                                    input logic [CHANNELS*WAIT_W-1:0] w,
                                                    input logic pick_min);
    logic [WAIT_W-1:0] best;
    logic seen;
    best = '0;
    seen = 1'b0;
    for (int i = 0; i < CHANNELS; i++)
    begin
      if (m[i])
      begin
        if (!seen)
          best = w[i*WAIT_W +: WAIT_W];
        else if (pick_min && w[i*WAIT_W +: WAIT_W] < best)
          best = w[i*WAIT_W +: WAIT_W];
        else if (!pick_min && w[i*WAIT_W +: WAIT_W] > best)
          best = w[i*WAIT_W +: WAIT_W];
        seen = 1'b1;
      end
    end
    merge_waits = best;
  endfunction

  wire qualified = cycle_internal && !pcb_access && !hold_active;
  wire [CHANNELS-1:0] hit = match & {CHANNELS{qualified}};
  wire any_hit = |hit;
  wire any_rdy = |(hit & ch_rdy);
  wire [WAIT_W-1:0] merged_wait = merge_waits(hit, ch_wait, any_rdy);
  wire timer_load = cycle_start && any_hit;

  // =====================================================================
  // select outputs, registered so they leave with the address in T1
  logic [CHANNELS-1:0] sel_n_reg, sel_n_next;
  logic [GEN_CHANNELS-1:0] port_reg, port_next;
  logic claim_reg, claim_next;

  assign sel_n_next = (hold_active || cycle_end) ? '1 :
                      cycle_start ? ~hit : sel_n_reg;
  assign claim_next = cycle_end ? 1'b0 : cycle_start ? any_hit : claim_reg;

  generate
    for (gi = 0; gi < GEN_CHANNELS; gi++)
    begin : g_port
      assign port_next[gi] = port1_csu_sel[gi] ? sel_n_next[gi] : port1_data[gi];
    end
  endgenerate

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      sel_n_reg <= '1;
      port_reg <= PORT_IDLE;
      claim_reg <= 1'b0;
    end
    else
    begin
      sel_n_reg <= sel_n_next;
      port_reg <= port_next;
      claim_reg <= claim_next;
    end
  end

  assign port1_pins = port_reg;
  assign lower_region_select_n = sel_n_reg[LOWER_CH];
  assign upper_boot_select_n = sel_n_reg[BOOT_CH];
  assign csu_claim = claim_reg;

  // =====================================================================
  // ready generation
  wait_ready_timer #(
    .CNT_W(WAIT_W)
  ) u_timer (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .load(timer_load),
    .wait_count(merged_wait),
    .use_ext(any_rdy),
    .ext_ready(ext_ready),
    .abort(cycle_end || hold_active),
    .ready(csu_ready)
  );

  // =====================================================================
  // checks
  hold_high_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    hold_active |=> (sel_n_reg == '1) && (csu_claim == 1'b0 || $past(claim_reg)))
    else $error("select driven low during bus hold");

  pcb_quiet_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (cycle_start && pcb_access) |=> sel_n_reg == '1)
    else $error("select asserted on a control block access");

  ext_master_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (cycle_start && !cycle_internal) |=> sel_n_reg == '1)
    else $error("select asserted for an external master cycle");

  overlap_sel_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (cycle_start && !cycle_end && !hold_active) |=> sel_n_reg == ~$past(hit))
    else $error("selects do not match every covering channel");

  no_match_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (cycle_start && !cycle_end && !any_hit) |=> !csu_claim ##1 !csu_ready)
    else $error("waits requested with no matching channel");

  boot_reset_a: assert property (@(posedge clk_sys)
    !reset_n |=> (ch_en == (1 << BOOT_CH)) && end_reg[BOOT_CH][IGN_END_BIT]
                 && (start_reg[BOOT_CH][FIELD_LSB +: FIELD_W] == '1))
    else $error("boot channel reset state wrong");

  boot_wait_a: assert property (@(posedge clk_sys)
    !reset_n |=> (start_reg[BOOT_CH][WAIT_LSB +: WAIT_W] == '1) && ch_rdy[BOOT_CH])
    else $error("boot channel reset waits wrong");

  pin_route_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (port1_csu_sel == '1) |=> port1_pins == sel_n_reg[GEN_CHANNELS-1:0])
    else $error("port pins do not carry the general selects");

  // =====================================================================
  // register and output checks
  rdata_idle_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !pcb_rd |=> pcb_rdata == '0)
    else $error("read data shown without a read");

  rdata_unmapped_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (pcb_rd && !reg_hit) |=> pcb_rdata == '0)
    else $error("unmapped read returned data");

  start_store_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (pcb_wr && reg_hit && !reg_is_end) |=> start_reg[$past(reg_ch)] == $past(pcb_wdata))
    else $error("start register write not stored");

  end_store_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (pcb_wr && reg_hit && reg_is_end) |=> end_reg[$past(reg_ch)] == $past(pcb_wdata))
    else $error("end register write not stored");

  io_range_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (cycle_start && !cycle_mem && cycle_addr[ADDR_W-1:IO_ADDR_W] != '0) |=> sel_n_reg == '1)
    else $error("select asserted for an address outside the i/o space");

  claim_track_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (cycle_start && !cycle_end) |=> csu_claim == $past(any_hit))
    else $error("claim does not follow the channel match");

  cycle_release_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cycle_end |=> (sel_n_reg == '1) && !csu_claim)
    else $error("selects or claim still active after cycle end");

  ready_pulse_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    csu_ready |=> !csu_ready)
    else $error("ready held longer than one cycle");

  ready_claim_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    csu_ready |-> claim_reg)
    else $error("ready given for an unclaimed cycle");

  port_reset_a: assert property (@(posedge clk_sys)
    !reset_n |=> port1_pins == PORT_IDLE)
    else $error("port pins not idle after reset");

  data_route_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (port1_csu_sel == '0) |=> port1_pins == $past(port1_data))
    else $error("port pins do not carry port data");

  generate
    for (gi = 0; gi < CHANNELS; gi++)
    begin : g_chk_ch
      disabled_high_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (cycle_start && !ch_en[gi]) |=> sel_n_reg[gi])
        else $error("disabled channel asserted");
      max_wait_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (hit[gi] && !any_rdy) |-> merged_wait >= ch_wait[gi*WAIT_W +: WAIT_W])
        else $error("fixed overlap did not take the largest wait");
      min_wait_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (hit[gi] && any_rdy) |-> merged_wait <= ch_wait[gi*WAIT_W +: WAIT_W])
        else $error("ready overlap did not take the smallest wait");
    end
  endgenerate

  overlap_c: cover property (@(posedge clk_sys) disable iff (!reset_n)
    cycle_start && $countones(hit) > 1);
  ext_wait_c: cover property (@(posedge clk_sys) disable iff (!reset_n)
    timer_load && any_rdy ##[1:40] csu_ready);
  hold_c: cover property (@(posedge clk_sys) disable iff (!reset_n)
    claim_reg && hold_active);
  io_hit_c: cover property (@(posedge clk_sys) disable iff (!reset_n)
    cycle_start && !cycle_mem && any_hit);
  fixed_wait_c: cover property (@(posedge clk_sys) disable iff (!reset_n)
    timer_load && !any_rdy ##[1:20] csu_ready);
endmodule

// ---- test/bus_device_model.sv ----
`timescale 1ns/10ps
// ==========
// far side: memory or peripheral answering on the ready line
module bus_device_model
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [9:0] sel_n,
  input wire logic [7:0] ready_delay,
  output logic ext_ready
);
  logic [7:0] wait_reg;
  logic picked;
  assign picked = ~&sel_n;
  // idle level high, valid through reset; once selected, ready rises after ready_delay cycles, so the boot channel stalls if that exceeds its waits
  assign ext_ready = (reset_n && picked) ? (wait_reg >= ready_delay) : 1'b1;
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n || !picked)
      wait_reg <= 8'h00;
    else if (wait_reg != 8'hff)
      wait_reg <= wait_reg + 8'h01;
  end
endmodule

// ---- test/tb_top.sv ----
`timescale 1ns/10ps
// ==========
// bench top: registers, decode, waits, refusals
module tb_top;
  logic clk_sys = 1'b0, reset_n = 1'b0, pcb_wr = 1'b0, pcb_rd = 1'b0;
  logic cycle_start = 1'b0, cycle_end = 1'b0, cycle_mem = 1'b1, cycle_internal = 1'b1;
  logic pcb_access = 1'b0, hold_active = 1'b0;
  logic [7:0] pcb_addr = 8'h00, port1_csu_sel = 8'hff, port1_data = 8'h5a;
  logic [7:0] ready_delay = 8'h00;
  logic [15:0] pcb_wdata = 16'h0000;
  logic [19:0] cycle_addr = 20'h0_0000;
  logic ext_ready, lower_region_select_n, upper_boot_select_n, csu_claim, csu_ready;
  logic [7:0] port1_pins;
  logic [15:0] pcb_rdata;
  logic [9:0] sel_n;
  int n_errors = 0;
  int cmp_count = 0;

  assign sel_n = {upper_boot_select_n, lower_region_select_n, port1_pins};
  always #2.5 clk_sys = ~clk_sys;

  chip_select_wait_state_unit uut
  (
    .clk_sys(clk_sys), .reset_n(reset_n), .pcb_wr(pcb_wr), .pcb_rd(pcb_rd),
    .pcb_addr(pcb_addr), .pcb_wdata(pcb_wdata), .pcb_rdata(pcb_rdata),
    .cycle_start(cycle_start), .cycle_end(cycle_end), .cycle_addr(cycle_addr),
    .cycle_mem(cycle_mem), .cycle_internal(cycle_internal), .pcb_access(pcb_access),
    .hold_active(hold_active), .ext_ready(ext_ready), .port1_csu_sel(port1_csu_sel),
    .port1_data(port1_data), .port1_pins(port1_pins),
    .lower_region_select_n(lower_region_select_n),
    .upper_boot_select_n(upper_boot_select_n), .csu_claim(csu_claim),
    .csu_ready(csu_ready)
  );

  bus_device_model far
  (
    .clk_sys(clk_sys), .reset_n(reset_n), .sel_n(sel_n), .ready_delay(ready_delay),
    .ext_ready(ext_ready)
  );

  // ==========
  // shared tasks
  task automatic check(input string what, input logic [19:0] exp, input logic [19:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    pcb_wr <= 1'b1;
    pcb_addr <= a;
    pcb_wdata <= d;
    @(posedge clk_sys);
    pcb_wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    pcb_rd <= 1'b1;
    pcb_addr <= a;
    @(posedge clk_sys);
    pcb_rd <= 1'b0;
    #1;
    check("register read", {4'h0, exp}, {4'h0, pcb_rdata});
  endtask

  // one bus cycle: select pattern in T1, ready cycle (-1 none), release
  task automatic bus_cycle(input logic [19:0] a, input logic m, input logic [9:0] exp_n,
                           input int exp_rdy);
    int k;
    k = -1;
    @(posedge clk_sys);
    cycle_addr <= a;
    cycle_mem <= m;
    cycle_start <= 1'b1;
    @(posedge clk_sys);
    cycle_start <= 1'b0;
    #1;
    check("selects", {10'h000, exp_n}, {10'h000, sel_n});
    check("claim", {19'h0_0000, exp_rdy >= 0}, {19'h0_0000, csu_claim});
    for (int i = 1; i < 40; i++)
    begin
      if (k < 0 && csu_ready === 1'b1)
        k = i;
      if (k < 0)
      begin
        @(posedge clk_sys);
        #1;
      end
    end
    check("ready cycle", 20'(exp_rdy), 20'(k));
    @(posedge clk_sys);
    cycle_end <= 1'b1;
    @(posedge clk_sys);
    cycle_end <= 1'b0;
    #1;
    check("released", {10'h000, 10'h3ff}, {10'h000, sel_n | {2'b00, ~port1_csu_sel}});
    check("claim off", 20'h0_0000, {18'h0_0000, csu_claim, csu_ready});
  endtask

  // ==========
  // scenarios
  task automatic t_reset();
    #1;
    check("idle selects", {10'h000, 10'h3ff}, {10'h000, sel_n});
    reg_rd(8'ha4, 16'hffcf);
    reg_rd(8'ha6, 16'hffcf);
    reg_rd(8'ha0, 16'h0000);
    reg_wr(8'h81, 16'h1234);
    reg_rd(8'h80, 16'h0000);
    reg_rd(8'h81, 16'h0000);
    reg_rd(8'ha8, 16'h0000);
  endtask

  task automatic t_boot();
    ready_delay <= 8'h00;
    bus_cycle(20'hf_fff0, 1'b1, 10'h1ff, 17);
    ready_delay <= 8'd20;
    bus_cycle(20'hf_ffff, 1'b1, 10'h1ff, 22);
    bus_cycle(20'hf_fbff, 1'b1, 10'h3ff, -1);
  endtask

  task automatic t_ranges();
    reg_wr(8'h80, 16'h0103);
    reg_wr(8'h82, 16'h014a);
    reg_wr(8'h88, 16'h0100);
    reg_wr(8'h8a, 16'h0142);
    reg_rd(8'h80, 16'h0103);
    ready_delay <= 8'hff;
    bus_cycle(20'h0_13ff, 1'b1, 10'h3fe, 5);
    bus_cycle(20'h0_1400, 1'b1, 10'h3ff, -1);
    bus_cycle(20'h0_0fff, 1'b1, 10'h3ff, -1);
  endtask

  task automatic t_overlap();
    reg_wr(8'h8c, 16'h0041);
    reg_wr(8'h8e, 16'h018a);
    reg_wr(8'ha0, 16'h0000);
    reg_wr(8'ha2, 16'h080a);
    bus_cycle(20'h0_1000, 1'b1, 10'h2f6, 5);
    bus_cycle(20'h0_7fff, 1'b1, 10'h2ff, 2);
    reg_wr(8'h82, 16'h014b);
    ready_delay <= 8'h00;
    bus_cycle(20'h0_1000, 1'b1, 10'h2f6, 2);
    @(posedge clk_sys);
    port1_csu_sel <= 8'h0f;
    bus_cycle(20'h0_1000, 1'b1, 10'h256, 2);
    @(posedge clk_sys);
    port1_csu_sel <= 8'hff;
  endtask

  // i/o window starts at 0140h, clear of the coprocessor ports
  task automatic t_io();
    reg_wr(8'h84, 16'h0142);
    reg_wr(8'h86, 16'h000c);
    bus_cycle(20'h0_0140, 1'b0, 10'h3fd, 4);
    bus_cycle(20'h0_ffff, 1'b0, 10'h3fd, 4);
    bus_cycle(20'h0_013f, 1'b0, 10'h3ff, -1);
    bus_cycle(20'h0_ffff, 1'b1, 10'h3ff, -1);
    bus_cycle(20'h1_0140, 1'b0, 10'h3ff, -1);
  endtask

  task automatic t_refuse();
    for (int j = 0; j < 3; j++)
    begin
      @(posedge clk_sys);
      cycle_internal <= (j != 0);
      pcb_access <= (j == 1);
      hold_active <= (j == 2);
      bus_cycle(20'h0_13ff, 1'b1, 10'h3ff, -1);
    end
    @(posedge clk_sys);
    hold_active <= 1'b0;
  endtask

  // hold arriving mid-cycle pulls the selects back high
  task automatic t_hold();
    @(posedge clk_sys);
    cycle_addr <= 20'h0_1000;
    cycle_mem <= 1'b1;
    cycle_start <= 1'b1;
    port1_csu_sel <= 8'h00;
    @(posedge clk_sys);
    cycle_start <= 1'b0;
    hold_active <= 1'b1;
    #1;
    check("pre-hold selects", 20'h0_0002, {18'h0_0000, sel_n[9:8]});
    @(posedge clk_sys);
    #1;
    check("hold selects", 20'h0_0003, {18'h0_0000, sel_n[9:8]});
    check("port data", 20'h0_005a, {12'h000, port1_pins});
    @(posedge clk_sys);
    hold_active <= 1'b0;
    cycle_end <= 1'b1;
    port1_csu_sel <= 8'hff;
    @(posedge clk_sys);
    cycle_end <= 1'b0;
    #1;
    check("hold claim off", 20'h0_0000, {18'h0_0000, csu_claim, csu_ready});
  endtask

  initial
  begin
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_boot();
    t_ranges();
    t_overlap();
    t_io();
    t_refuse();
    t_hold();
    summarize();
  end

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    $display("mismatch watchdog expected done seen hang");
    summarize();
  end
endmodule
